/* src/sysad_pkg.sv */
package sysad_pkg;
  // command field codes, bits 7:5 and 4:3 of the command bus
  localparam logic [2:0] CMD_READ    = 3'h0;
  localparam logic [2:0] CMD_WRITE   = 3'h2;
  localparam logic [1:0] ATTR_BLOCK  = 2'h2;
  localparam logic [1:0] ATTR_SINGLE = 2'h3;
  // block size codes, bits 1:0 (code 2 reserved)
  localparam logic [1:0] BSZ_4W      = 2'h0;
  localparam logic [1:0] BSZ_8W      = 2'h1;
  localparam logic [1:0] BSZ_6W      = 2'h3;
  // single-access data size codes
  localparam logic [2:0] SZ_WORD     = 3'h3;
  localparam logic [2:0] SZ_DWORD    = 3'h7;
  // data identifier bit positions
  localparam int DID_FLAG  = 8;
  localparam int DID_LAST  = 7;
  localparam int DID_ERR   = 5;
  localparam int DID_NOCHK = 4;
  // bus tenure limit, write-ready slack and own address window
  localparam logic [3:0] MAX_REQS    = 4'h8;
  localparam int         WR_SLACK    = 2;
  localparam logic [31:0] DEV_BASE   = 32'h1F00_0000;
  localparam logic [31:0] DEV_MASK   = 32'hFFF0_0000;
  // write-path pixel formats
  typedef enum logic [2:0] {
    FMT_PACKED   = 3'b000,
    FMT_LUMA     = 3'b001,
    FMT_CHROMA   = 3'b010,
    FMT_MERGE    = 3'b011,
    FMT_MERGE420 = 3'b100
  } fmt_e;
  // bus master states
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_REQ  = 3'b001,
    S_ADDR = 3'b010,
    S_DATA = 3'b011,
    S_REL  = 3'b100,
    S_RESP = 3'b101
  } mstate_e;
endpackage

/* src/sysad_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
// small first-word-fall-through queue; DEPTH must be a power of two
module sysad_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         rstn,
  // fill side
  input  wire logic                         inValid,
  output logic                              inReady,
  input  wire logic [WIDTH-1:0]             inData,
  // drain side
  output logic                              outValid,
  input  wire logic                         outReady,
  output logic [WIDTH-1:0]                  outData,
  output logic [$clog2(DEPTH+1)-1:0]        level
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int LW = $clog2(DEPTH+1);
  logic [WIDTH-1:0] mem [DEPTH];   // storage, no reset needed
  logic [AW-1:0]    wrPtr;         // next slot to fill
  logic [AW-1:0]    rdPtr;         // oldest slot
  wire push = inValid & inReady;
  wire pop  = outValid & outReady;
  assign inReady  = level != LW'(DEPTH);
  assign outValid = level != '0;
  assign outData  = mem[rdPtr];
  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end
  // pointers and fill level
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr <= '0;
      rdPtr <= '0;
      level <= '0;
    end else begin
      if (push) wrPtr <= wrPtr + AW'(1);
      if (pop) rdPtr <= rdPtr + AW'(1);
      level <= level + LW'(push) - LW'(pop);
    end
  end
endmodule
`default_nettype wire

/* src/sysad_host_dma_interface.sv */
// Contract
// - drop write-ready when host buffer nearly full
// - keep room for two late host writes
// - host valid-out plus decode starts slave cycles
// - drive own valid-in for host reads
// - request bus, wait for grant
// - use master lines, honour write/read ready
// - reads doubleword aligned, 8 to 32 bytes; word-only reads go out as 4-byte SZ_WORD reads at curAddr
// - single doubleword uses non-block command
// - mix single and block reads freely
// - never cross a 32-byte memory word
// - release after eight requests, await responses
// - queue upper/lower validity per response doubleword
// - small accesses use full size encoding
// - rectangles with line skips, split spans
// - block writes: address then 2-4 doublewords
// - realign unaligned writes at next doubleword
// - extract luma/chroma, duplicate chroma for 4:2:0
// - even parity on address, command, data
// - check-enable bit from config, default off
// - bus edges found from link clock, FIFOs cross
// - block size codes 0,1,3 mean 4,8,6 words
// - erroneous response data raises interrupt
`timescale 1ns/1ps
`default_nettype none
module sysad_host_dma_interface #(
  parameter int HOST_DEPTH = 4
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // bus pins
  input  wire logic        system_bus_clock,
  input  wire logic [63:0] sysAdIn,
  output logic      [63:0] sysAdOut,
  output logic      [7:0]  sysAdChk,
  input  wire logic [8:0]  sysCmdIn,
  output logic      [8:0]  sysCmdOut,
  output logic             sysCmdChk,
  output logic             busOe_n,
  input  wire logic        hostValidOut_n,
  output logic             host_read_valid_drive_n,
  output logic             dev_write_ready_n,
  output logic             bus_request_n,
  input  wire logic        bus_grant_n,
  input  wire logic        master_valid_in_n,
  output logic             master_valid_out_n,
  output logic             master_release_n,
  input  wire logic        wrRdy_n,
  input  wire logic        rdRdy_n,
  output logic             dev_interrupt_n,
  // host writes toward internals
  output logic             hostWrValid,
  input  wire logic        hostWrReady,
  output logic [98:0]      hostWrEntry,
  // host reads from internals
  output logic             hostRdReq,
  output logic      [31:0] hostRdAddr,
  output logic      [2:0]  hostRdSize,
  input  wire logic        hostRdDone,
  input  wire logic [63:0] hostRdData,
  // dma command
  input  wire logic        dmaValid,
  output logic             dmaReady,
  input  wire logic        dmaWrite,
  input  wire logic [31:0] dmaAddr,
  input  wire logic [8:0]  dmaLineBytes,
  input  wire logic [7:0]  dmaLines,
  input  wire logic [15:0] dmaStride,
  input  wire logic [2:0]  dmaMode,
  // dma write data
  input  wire logic        wrValid,
  output logic             wrReady,
  input  wire logic [31:0] wrA,
  input  wire logic [31:0] wrB,
  output logic             chromaRepeat,
  // dma read data
  output logic             rdValid,
  output logic      [63:0] rdData,
  output logic      [1:0]  rdMask,
  // configuration
  input  wire logic        cfgDataCheck,
  input  wire logic        intAck
);
  localparam int PW = 79;
  localparam int LW = $clog2(HOST_DEPTH+1);

  // three-stage pin sampling, bitwise agreement filter
  wire  [PW-1:0] pinRaw = {system_bus_clock, hostValidOut_n, bus_grant_n, master_valid_in_n,
                           wrRdy_n, rdRdy_n, sysCmdIn, sysAdIn};
  logic [PW-1:0] s1, s2, s3;   // raw sampling chain
  logic [PW-1:0] pin;          // filtered pin levels
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s1 <= {PW{1'b1}};
      s2 <= {PW{1'b1}};
      s3 <= {PW{1'b1}};
    end else begin
      s1 <= pinRaw;
      s2 <= s1;
      s3 <= s2;
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < PW; gi++) begin : g_filt
      // a change counts only once stages two and three agree
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) pin[gi] <= 1'b1;
        else if (s2[gi] == s3[gi]) pin[gi] <= s3[gi];
      end
    end
  endgenerate
  wire        pSclk   = pin[78];
  wire        pHost_n = pin[77];
  wire        pGnt_n  = pin[76];
  wire        pVin_n  = pin[75];
  wire        pWrRdy_n = pin[74];
  wire        pRdRdy_n = pin[73];
  wire  [8:0] pCmd    = pin[72:64];
  wire [63:0] pAd     = pin[63:0];

  // bus clock rising edge becomes a one-cycle enable
  logic sclkLast;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) sclkLast <= 1'b1;
    else sclkLast <= pSclk;
  end
  wire sEdge = pSclk & ~sclkLast;

  // master engine state
  sysad_pkg::mstate_e state;
  logic [31:0] curAddr, lineBase;   // walk position
  logic [8:0]  lineLeft, lineBytes; // bytes left in line, line length
  logic [7:0]  linesLeft;           // lines still to walk
  logic [15:0] stride;              // line skip distance
  logic        isWrite, lineOdd, walkDone, checkEn, wrPend, rdPend, rdDrive;
  logic [3:0]  reqCount, outstanding;
  logic [2:0]  dwLeft, mode;
  logic [31:0] pendAddr;
  logic [2:0]  pendSize;
  logic [63:0] rdHold, dwHold;
  logic [1:0]  halfHave;
  wire busOwned = (state == sysad_pkg::S_ADDR) || (state == sysad_pkg::S_DATA);

  // slave decode of processor cycles
  wire cmdCycle = ~pCmd[sysad_pkg::DID_FLAG];
  wire hit      = (pAd[31:0] & sysad_pkg::DEV_MASK) == sysad_pkg::DEV_BASE;
  wire hostAddr = sEdge & ~pHost_n & cmdCycle & hit & ~busOwned;
  wire isBlk    = pCmd[4:3] == sysad_pkg::ATTR_BLOCK;
  wire blkHit   = hostAddr & isBlk;
  wire hostWrA  = hostAddr & ~isBlk & (pCmd[7:5] == sysad_pkg::CMD_WRITE);
  wire hostRdA  = hostAddr & ~isBlk & (pCmd[7:5] == sysad_pkg::CMD_READ);
  wire hostData = sEdge & ~pHost_n & ~cmdCycle & wrPend;
  wire hostRdBusy = rdPend | rdDrive;

  // host write buffer
  logic [LW-1:0] hostLevel;
  sysad_fifo #(.WIDTH(99), .DEPTH(HOST_DEPTH)) u_hostq (
    .clk(sys_clk), .rstn(rstn), .inValid(hostData), .inReady(),
    .inData({pendAddr, pAd, pendSize}), .outValid(hostWrValid),
    .outReady(hostWrReady), .outData(hostWrEntry), .level(hostLevel));
  // free slots, counting a write whose data is still due
  wire [LW:0] hostFree = (LW+1)'(HOST_DEPTH) - {1'b0, hostLevel} - (LW+1)'(wrPend);

  // slave cycle tracking
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wrPend <= 1'b0;
      rdPend <= 1'b0;
      rdDrive <= 1'b0;
      pendAddr <= 32'h0000_0000;
      pendSize <= 3'h0;
      hostRdReq <= 1'b0;
      hostRdAddr <= 32'h0000_0000;
      hostRdSize <= 3'h0;
      rdHold <= 64'h0;
      dev_write_ready_n <= 1'b1;
    end else begin
      hostRdReq <= hostRdA;
      // stop the host while two late writes still fit
      dev_write_ready_n <= hostFree <= (LW+1)'(sysad_pkg::WR_SLACK);
      if (hostWrA) begin
        wrPend <= 1'b1;
        pendAddr <= pAd[31:0];
        pendSize <= pCmd[2:0];
      end else if (hostData) begin
        wrPend <= 1'b0;
      end
      if (hostRdA) begin
        rdPend <= 1'b1;
        hostRdAddr <= pAd[31:0];
        hostRdSize <= pCmd[2:0];
      end else if (rdPend && hostRdDone) begin
        rdPend <= 1'b0;
        rdDrive <= 1'b1;
        rdHold <= hostRdData;
      end else if (rdDrive && sEdge) begin
        rdDrive <= 1'b0;
      end
    end
  end

  // sticky interrupt, set wins over acknowledge
  wire respErr = (state == sysad_pkg::S_RESP) & sEdge & ~pVin_n & pCmd[sysad_pkg::DID_FLAG]
                 & pCmd[sysad_pkg::DID_ERR];
  wire hostErr = hostData & pCmd[sysad_pkg::DID_ERR];
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) dev_interrupt_n <= 1'b1;
    else if (blkHit || respErr || hostErr) dev_interrupt_n <= 1'b0;
    else if (intAck) dev_interrupt_n <= 1'b1;
  end

  // configuration: resets to no checking
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) checkEn <= 1'b0;
    else checkEn <= cfgDataCheck;
  end

  // request splitting within a line
  wire       wordOnly = curAddr[2] | (lineLeft < 9'h008);
  wire [2:0] room     = 3'h4 - {1'b0, curAddr[4:3]};
  wire [5:0] lineDw   = lineLeft[8:3];
  wire [2:0] nDw      = (lineDw >= {3'h0, room}) ? room : lineDw[2:0];
  wire [8:0] chunk    = wordOnly ? 9'h004 : {3'h0, nDw, 3'h0};
  wire       single   = wordOnly | (nDw == 3'h1);
  wire [1:0] bsz      = (nDw == 3'h2) ? sysad_pkg::BSZ_4W :
                        (nDw == 3'h3) ? sysad_pkg::BSZ_6W : sysad_pkg::BSZ_8W;
  wire [2:0] szField  = single ? (wordOnly ? sysad_pkg::SZ_WORD : sysad_pkg::SZ_DWORD)
                               : {1'b0, bsz};
  wire [1:0] needMask = wordOnly ? (curAddr[2] ? 2'h2 : 2'h1) : 2'h3;
  wire [31:0] reqAddr = wordOnly ? curAddr : {curAddr[31:3], 3'h0};
  wire       lastChunk = lineLeft == chunk;
  wire [8:0] cmdAddrW = {1'b0, isWrite ? sysad_pkg::CMD_WRITE : sysad_pkg::CMD_READ,
                         single ? sysad_pkg::ATTR_SINGLE : sysad_pkg::ATTR_BLOCK, szField};

  // validity queue for read responses
  logic       qReady, qValid;
  logic [1:0] qMask;
  wire issueRd = sEdge & (state == sysad_pkg::S_ADDR) & ~isWrite & ~pRdRdy_n & qReady;
  wire issueWr = sEdge & (state == sysad_pkg::S_ADDR) & isWrite & ~pWrRdy_n;
  wire respDw  = sEdge & (state == sysad_pkg::S_RESP) & ~pVin_n & pCmd[sysad_pkg::DID_FLAG];
  wire respEnd = respDw & ~pCmd[sysad_pkg::DID_LAST];
  sysad_fifo #(.WIDTH(2), .DEPTH(8)) u_maskq (
    .clk(sys_clk), .rstn(rstn), .inValid(issueRd), .inReady(qReady), .inData(needMask),
    .outValid(qValid), .outReady(respEnd), .outData(qMask), .level());

  // write data: format, then two-entry buffer toward the bus
  logic [31:0] fmtWord;
  always_comb begin
    case (mode)
      sysad_pkg::FMT_LUMA:     fmtWord = {wrB[23:16], wrB[7:0], wrA[23:16], wrA[7:0]};
      sysad_pkg::FMT_CHROMA:   fmtWord = {wrB[31:24], wrB[15:8], wrA[31:24], wrA[15:8]};
      sysad_pkg::FMT_MERGE,
      sysad_pkg::FMT_MERGE420: fmtWord = {wrB[15:8], wrA[15:8], wrB[7:0], wrA[7:0]};
      default:                 fmtWord = wrA;
    endcase
  end
  logic        bufValid;
  logic [31:0] bufWord;
  wire dwReady = (halfHave & needMask) == needMask;
  wire sendDw  = sEdge & (state == sysad_pkg::S_DATA) & dwReady;
  wire gather  = isWrite & (state != sysad_pkg::S_IDLE) & ~sendDw & ~dwReady;
  wire bufPop  = gather & bufValid;
  sysad_fifo #(.WIDTH(32), .DEPTH(2)) u_wrbuf (
    .clk(sys_clk), .rstn(rstn), .inValid(wrValid), .inReady(wrReady), .inData(fmtWord),
    .outValid(bufValid), .outReady(bufPop), .outData(bufWord), .level());

  // doubleword assembly; lower address word sits in bits 31:0
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dwHold <= 64'h0;
      halfHave <= 2'h0;
    end else if (sendDw) begin
      halfHave <= 2'h0;
    end else if (bufPop && needMask[0] && !halfHave[0]) begin
      dwHold[31:0] <= bufWord;
      halfHave[0] <= 1'b1;
    end else if (bufPop) begin
      dwHold[63:32] <= bufWord;
      halfHave[1] <= 1'b1;
    end
  end

  // master sequencing and rectangle walk
  wire advance = issueRd | (sendDw & (dwLeft == 3'h1));
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state <= sysad_pkg::S_IDLE;
      {curAddr, lineBase, stride} <= 80'h0;
      {lineLeft, lineBytes, linesLeft} <= 26'h0;
      {isWrite, lineOdd, walkDone, mode, dwLeft} <= 9'h0;
      reqCount <= 4'h0;
      outstanding <= 4'h0;
    end else begin
      if (advance) begin
        reqCount <= reqCount + 4'h1;
        if (!lastChunk) begin
          curAddr <= curAddr + {23'h0, chunk};
          lineLeft <= lineLeft - chunk;
        end else if (linesLeft == 8'h01) begin
          walkDone <= 1'b1;
        end else begin
          // skip to the next line of the rectangle
          lineBase <= lineBase + {16'h0, stride};
          curAddr <= lineBase + {16'h0, stride};
          lineLeft <= lineBytes;
          linesLeft <= linesLeft - 8'h01;
          lineOdd <= ~lineOdd;
        end
      end
      case (state)
        sysad_pkg::S_IDLE: if (dmaValid && dmaReady) begin
          {curAddr, lineBase} <= {dmaAddr, dmaAddr};
          {lineLeft, lineBytes} <= {dmaLineBytes, dmaLineBytes};
          {linesLeft, stride, mode} <= {dmaLines, dmaStride, dmaMode};
          {isWrite, lineOdd, walkDone} <= {dmaWrite, 2'b00};
          state <= sysad_pkg::S_REQ;
        end
        // host reads are finished before the bus is asked for
        sysad_pkg::S_REQ: if (sEdge && !pGnt_n && !hostRdBusy) begin
          reqCount <= 4'h0;
          state <= sysad_pkg::S_ADDR;
        end
        sysad_pkg::S_ADDR: if (issueWr) begin
          dwLeft <= single ? 3'h1 : nDw;
          state <= sysad_pkg::S_DATA;
        end else if (issueRd) begin
          outstanding <= outstanding + 4'h1;
          if (lastChunk && linesLeft == 8'h01 || reqCount == sysad_pkg::MAX_REQS - 4'h1)
            state <= sysad_pkg::S_REL;
        end
        sysad_pkg::S_DATA: if (sendDw) begin
          dwLeft <= dwLeft - 3'h1;
          if (dwLeft == 3'h1)
            state <= (lastChunk && linesLeft == 8'h01 || reqCount == sysad_pkg::MAX_REQS - 4'h1)
                     ? sysad_pkg::S_REL : sysad_pkg::S_ADDR;
        end
        sysad_pkg::S_REL: if (sEdge) begin
          state <= !isWrite ? sysad_pkg::S_RESP : walkDone ? sysad_pkg::S_IDLE : sysad_pkg::S_REQ;
        end
        sysad_pkg::S_RESP: if (respEnd) begin
          outstanding <= outstanding - 4'h1;
        end else if (outstanding == 4'h0) begin
          state <= walkDone ? sysad_pkg::S_IDLE : sysad_pkg::S_REQ;
        end
        default: state <= sysad_pkg::S_IDLE;
      endcase
    end
  end

  // user-facing status and read data
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dmaReady <= 1'b0;
      chromaRepeat <= 1'b0;
      rdValid <= 1'b0;
      rdData <= 64'h0;
      rdMask <= 2'h0;
    end else begin
      dmaReady <= (state == sysad_pkg::S_IDLE) && !hostRdBusy && !(dmaValid && dmaReady);
      // source replays the chroma line on odd lines
      chromaRepeat <= lineOdd && (mode == sysad_pkg::FMT_MERGE420);
      rdValid <= respDw;
      if (respDw) begin
        rdData <= pAd;
        rdMask <= qValid ? qMask : 2'h3;
      end
    end
  end

  // bus pin drive, refreshed once per bus clock
  wire [8:0] didOut = {1'b1, 1'b0, 1'b0, 1'b0, ~checkEn, 4'h0};
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sysAdOut <= 64'h0;
      sysCmdOut <= 9'h000;
      busOe_n <= 1'b1;
      host_read_valid_drive_n <= 1'b1;
      master_valid_out_n <= 1'b1;
      master_release_n <= 1'b1;
      bus_request_n <= 1'b1;
    end else if (sEdge) begin
      busOe_n <= 1'b1;
      host_read_valid_drive_n <= 1'b1;
      master_valid_out_n <= 1'b1;
      master_release_n <= 1'b1;
      bus_request_n <= !((state == sysad_pkg::S_REQ) && !hostRdBusy);
      if (issueRd || issueWr) begin
        sysAdOut <= {32'h0, reqAddr};
        sysCmdOut <= cmdAddrW;
        busOe_n <= 1'b0;
        master_valid_out_n <= 1'b0;
        bus_request_n <= 1'b0;
      end else if (sendDw) begin
        sysAdOut <= dwHold;
        sysCmdOut <= {1'b1, dwLeft != 3'h1, 1'b1, didOut[5:0]};
        busOe_n <= 1'b0;
        master_valid_out_n <= 1'b0;
        bus_request_n <= 1'b0;
      end else if (busOwned) begin
        bus_request_n <= 1'b0;
      end else if (state == sysad_pkg::S_REL) begin
        master_release_n <= 1'b0;
      end else if (rdDrive) begin
        sysAdOut <= rdHold;
        sysCmdOut <= didOut;
        busOe_n <= 1'b0;
        host_read_valid_drive_n <= 1'b0;
      end
    end
  end

  // even parity, one cycle behind the driven values
  generate
    for (gi = 0; gi < 8; gi++) begin : g_par
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) sysAdChk[gi] <= 1'b0;
        else sysAdChk[gi] <= ^sysAdOut[8*gi +: 8];
      end
    end
  endgenerate
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) sysCmdChk <= 1'b0;
    else sysCmdChk <= ^sysCmdOut;
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_wr_ready_slack: assert property (
    hostData |-> hostLevel != LW'(HOST_DEPTH))
    else $error("late host write found no room");
  a_block_hit_irq: assert property (
    blkHit |=> !dev_interrupt_n && !hostRdReq && !wrPend)
    else $error("block access to own space not flagged or not ignored");
  a_grant_first: assert property (
    $fell(master_valid_out_n) |-> !bus_request_n && (busOwned || state == sysad_pkg::S_REL))
    else $error("master cycle without bus ownership");
  a_tenure_cap: assert property (
    issueRd && reqCount == 4'h7 |=> state == sysad_pkg::S_REL)
    else $error("bus not released after eight requests");
  a_word_bound: assert property (
    issueRd || issueWr |-> {1'b0, curAddr[4:0]} + {1'b0, chunk[5:0]} <= 7'h20)
    else $error("request crosses a 32-byte word");
  a_single_dw: assert property (
    (issueRd || issueWr) && single |=> sysCmdOut[4:3] == sysad_pkg::ATTR_SINGLE && !busOe_n)
    else $error("single doubleword sent as block");
  a_read_align: assert property (
    issueRd && !wordOnly |=> sysAdOut[2:0] == 3'h0 && sysCmdOut[1:0] != 2'h2)
    else $error("block read misaligned or reserved size");
  a_parity_even: assert property (
    !busOe_n ##1 $stable(sysAdOut) |-> (^{sysAdOut, sysAdChk}) == 1'b0)
    else $error("address/data parity not even");
  a_check_default: assert property (
    !checkEn && !busOe_n && sysCmdOut[8] |-> sysCmdOut[4])
    else $error("check-enable bit wrong in data identifier");
endmodule
`default_nettype wire

/* testbench/mem_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
// controller stand-in: grants, logs requests, answers after release
module mem_ctrl_model (
  // link clock and reset
  input  wire logic       bclk,
  input  wire logic       rstn,
  // device master lines
  input  wire logic       bus_request_n,
  input  wire logic       master_valid_out_n,
  input  wire logic       master_release_n,
  input  wire logic [8:0] sysCmdOut,
  // controller drive
  output logic            bus_grant_n,
  output logic            master_valid_in_n,
  output logic            drive,
  output logic [63:0]     respAd,
  output logic [8:0]      respCmd
);
  int   beats[$];  // beats owed per request
  int   gap;       // link cycles under request
  int   n;         // running beat number
  int   k;         // beat within request
  logic answering; // release seen
  function automatic int size_of(input logic [8:0] c);
    if (c[4:3] != sysad_pkg::ATTR_BLOCK) return 1;
    return c[1:0] == sysad_pkg::BSZ_4W ? 2 : c[1:0] == sysad_pkg::BSZ_8W ? 4 : 3;
  endfunction
  // moves at the falling link edge so the device samples settled levels
  always @(negedge bclk or negedge rstn) begin
    if (!rstn) begin
      bus_grant_n <= 1'b1;
      master_valid_in_n <= 1'b1;
      drive <= 1'b0;
      respAd <= 64'h0;
      respCmd <= 9'h0;
      answering = 1'b0;
      gap = 0;
      n = 0;
      k = 0;
    end else begin
      // taking the bus from the host costs at least four cycles
      gap = bus_request_n ? 0 : gap + 1;
      bus_grant_n <= !(gap >= 4);
      if (!master_valid_out_n && !sysCmdOut[8])
        beats.push_back(size_of(sysCmdOut));
      if (!master_release_n)
        answering = 1'b1;
      drive <= answering && beats.size() > 0;
      master_valid_in_n <= !(answering && beats.size() > 0);
      respAd <= {32'hA5A5_A5A5, 24'h0, n[7:0]};
      if (answering && beats.size() > 0) begin
        respCmd <= {1'b1, k != beats[0] - 1, 7'h0};
        n++;
        k++;
        if (k == beats[0]) begin
          k = 0;
          void'(beats.pop_front());
        end
      end else
        answering = 1'b0;
    end
  end
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk = 1'b0, system_bus_clock = 1'b0, rstn = 1'b0;
  int mismatches = 0, total_checks = 0, seen = 0;
  logic [63:0] hAd = 64'h0, hostRdData = 64'h0;
  logic [8:0] hCmd = 9'h0, dmaLineBytes = 9'h0;
  logic hostValidOut_n = 1'b1, hostWrReady = 1'b0, intAck = 1'b0, dmaValid = 1'b0, hostRdDone = 1'b0;
  logic wrValid = 1'b0, cfgDataCheck = 1'b0, dmaWrite = 1'b0, wrRdy_n = 1'b0, rdRdy_n = 1'b0;
  logic [31:0] dmaAddr = 32'h0, wrA = 32'h0, wrB = 32'h0;
  logic [15:0] dmaStride = 16'h0100;
  logic [7:0] dmaLines = 8'h1;
  logic [2:0] dmaMode = 3'h0;
  wire [63:0] sysAdOut, rdData, pAd, sysAdIn;
  wire [98:0] hostWrEntry;
  wire [31:0] hostRdAddr;
  wire [8:0] sysCmdOut, pCmd, sysCmdIn;
  wire [7:0] sysAdChk;
  wire [2:0] hostRdSize;
  wire [1:0] rdMask;
  wire sysCmdChk, busOe_n, host_read_valid_drive_n, dev_write_ready_n, bus_request_n, bus_grant_n;
  wire master_valid_in_n, master_valid_out_n, master_release_n, dev_interrupt_n, hostWrValid;
  wire hostRdReq, dmaReady, wrReady, chromaRepeat, rdValid, pDrive;
  // shared lines: device first, then controller, then host
  assign sysAdIn = !busOe_n ? sysAdOut : pDrive ? pAd : hAd;
  assign sysCmdIn = !busOe_n ? sysCmdOut : pDrive ? pCmd : hCmd;
  sysad_host_dma_interface DUT (.*);
  mem_ctrl_model PEER (.bclk(system_bus_clock), .rstn, .bus_request_n, .master_valid_out_n, .master_release_n,
    .sysCmdOut, .bus_grant_n, .master_valid_in_n, .drive(pDrive), .respAd(pAd), .respCmd(pCmd));
  always #12.5 sys_clk = ~sys_clk;
  always #100 system_bus_clock = ~system_bus_clock;
  task automatic check(input logic [127:0] got, input logic [127:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // host address cycle, optionally followed by its data cycle
  task automatic host_bus(input logic [8:0] cmd, input logic [31:0] a, input logic [63:0] d, input bit both);
    @(negedge system_bus_clock);
    hostValidOut_n = 1'b0;
    hCmd = cmd;
    hAd = {32'h0, a};
    if (both) begin
      @(negedge system_bus_clock);
      hCmd = 9'h140;
      hAd = d;
    end
    @(negedge system_bus_clock);
    hostValidOut_n = 1'b1;
    hAd = ~hAd;
  endtask
  // four writes into a stalled consumer, then drain in order
  task automatic write_flow();
    logic [31:0] a;
    for (int i = 0; i < 8; i++) begin
      a = 32'h1F00_0010 + 32'(8 * (i % 4));
      if (i == 4) hostWrReady = 1'b1;
      if (i < 4) begin
        host_bus({1'b0, sysad_pkg::CMD_WRITE, sysad_pkg::ATTR_SINGLE, sysad_pkg::SZ_DWORD}, a, {32'hC0DE_0000, a}, 1'b1);
        repeat (6) @(negedge sys_clk);
        check(dev_write_ready_n, i != 0);
      end else begin
        for (int t = 0; t < 9 && hostWrValid !== 1'b1; t++) @(negedge sys_clk);
        check(hostWrEntry, {a, 32'hC0DE_0000, a, sysad_pkg::SZ_DWORD});
        @(negedge sys_clk);
      end
    end
    hostWrReady = 1'b0;
  endtask
  // host read of own space, answered by the device
  task automatic host_read();
    host_bus({1'b0, sysad_pkg::CMD_READ, sysad_pkg::ATTR_SINGLE, sysad_pkg::SZ_DWORD}, 32'h1F00_0008, 64'h0, 1'b0);
    for (int t = 0; t < 9 && hostRdReq !== 1'b1; t++) @(negedge sys_clk);
    check({hostRdReq, hostRdAddr, hostRdSize}, {1'b1, 32'h1F00_0008, sysad_pkg::SZ_DWORD});
    hostRdData = 64'h1234;
    hostRdDone = 1'b1;
    @(negedge sys_clk);
    hostRdDone = 1'b0;
    for (int t = 0; t < 20 && host_read_valid_drive_n !== 1'b0; t++) @(negedge sys_clk);
    check({host_read_valid_drive_n, busOe_n, sysAdOut, sysCmdOut}, {2'h0, 64'h1234, 9'h110});
  endtask
  // block write to own space is dropped and flagged
  task automatic block_own();
    host_bus({1'b0, sysad_pkg::CMD_WRITE, sysad_pkg::ATTR_BLOCK, 1'b0, sysad_pkg::BSZ_4W}, 32'h1F00_0040, 64'h0, 1'b0);
    repeat (4) @(negedge sys_clk);
    check({dev_interrupt_n, hostWrValid}, 2'h0);
    intAck = 1'b1;
    @(negedge sys_clk);
    intAck = 1'b0;
    @(negedge sys_clk);
    check(dev_interrupt_n, 1'b1);
  endtask
  // one dma read; masks hold the first four beats, later beats are whole
  task automatic dma_read(input logic [31:0] a, input logic [8:0] len, input logic [7:0] ln, input logic [7:0] masks,
    input int beats);
    logic [1:0] m;
    @(negedge sys_clk);
    dmaAddr = a;
    dmaLineBytes = len;
    dmaLines = ln;
    dmaValid = 1'b1;
    for (int t = 0; t < 99 && dmaReady !== 1'b1; t++) @(negedge sys_clk);
    @(negedge sys_clk);
    dmaValid = 1'b0;
    for (int b = 0; b < beats; b++) begin
      for (int t = 0; t < 4000 && rdValid !== 1'b1; t++) @(negedge sys_clk);
      m = b < 4 ? masks[2*b +: 2] : 2'h3;
      check({rdValid, rdMask, rdData}, {1'b1, m, 32'hA5A5_A5A5, 24'h0, 8'(seen)});
      seen++;
      @(negedge sys_clk);
    end
  endtask
  task automatic conclude();
    if (mismatches == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge sys_clk);
    check({bus_request_n, busOe_n, dev_interrupt_n, master_release_n, rdValid, dmaReady}, 6'h3C);
    @(negedge sys_clk);
    rstn = 1'b1;
    repeat (8) @(negedge sys_clk);
    write_flow();
    block_own();
    host_read();
    dma_read(32'h0000_0014, 9'h010, 8'h01, 8'h1E, 3);
    dma_read(32'h0000_0040, 9'h020, 8'h01, 8'hFF, 4);
    dma_read(32'h0000_0048, 9'h010, 8'h01, 8'h0F, 2);
    dma_read(32'h0000_0060, 9'h018, 8'h01, 8'h3F, 3);
    dma_read(32'h0000_0100, 9'h0A0, 8'h02, 8'hFF, 40);
    conclude();
  end
  // hang guard, several times the expected run
  initial begin
    #1ms;
    mismatches++;
    conclude();
  end
endmodule
`default_nettype wire
